// ---- mmf_core.sv ----
// maintenance multiframe messaging: NT transmit queueing, TE receive validation
// assumes mf_boundary pulses once per multiframe and all inputs are on mclk
// What this block and its firmware do
// [RULE1] after the enable command, raise the tick interrupt every 30 ms
// [RULE2] high priority queue holds two 4-bit entries, each sent one multiframe
// [RULE3] at each boundary send queued high entry, else low priority value
// [RULE4] third write to full queue drops oldest and takes newer slot
// [RULE5] line code violation shows on the receive multiframe error output
// [RULE6] terminal LP, DTSE, FECV interrupt on every single occurrence
// [RULE7] other SC1 messages interrupt once after three identical receptions
// [RULE8] SC2 commands interrupt once after three identical receptions
// [RULE9] firmware ranks low priority messages and writes them via low register
// [RULE10] firmware sends LP, FECV, DTSE once through the high register
// [RULE11] firmware writes highest pending low message at each tick
// [RULE12] firmware loads DTSE or FECV into high register at once
// [RULE13] firmware extends current low message one tick after high writes
// [RULE14] firmware writes LP to both registers when power fails
// [RULE15] firmware writes first pending SC2 command at each tick
// [RULE16] low register value repeats each free multiframe until rewritten
`timescale 1ns/10ps
module mmf_core #(
    parameter int unsigned TICK_CYCLES = mmf_pkg::TICK_CYCLES
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       tick_interrupt_enable_cmd,
    input  wire logic                       sc1_low_priority_tx_we,
    input  wire logic [mmf_pkg::MSG_W-1:0] sc1_low_priority_tx_wdata,
    input  wire logic                       sc1_high_priority_tx_queue_we,
    input  wire logic [mmf_pkg::MSG_W-1:0] sc1_high_priority_tx_queue_wdata,
    input  wire logic                       sc2_tx_we,
    input  wire logic [mmf_pkg::MSG_W-1:0] sc2_tx_wdata,
    input  wire logic                       mf_boundary,
    input  wire logic                       s_loop_code_violation,
    input  wire logic                       rx_sc1_valid,
    input  wire logic [mmf_pkg::MSG_W-1:0] rx_sc1_data,
    input  wire logic                       rx_sc2_valid,
    input  wire logic [mmf_pkg::MSG_W-1:0] rx_sc2_data,
    output logic [mmf_pkg::MSG_W-1:0]      sc1_line_tx,
    output logic                            sc1_line_high,
    output logic [mmf_pkg::MSG_W-1:0]      sc2_line_tx,
    output logic                            multiframe_tick_interrupt,
    output logic                            rx_multiframe_error,
    output logic                            rx_sc1_irq,
    output logic [mmf_pkg::MSG_W-1:0]      rx_sc1_irq_data,
    output logic                            rx_sc2_irq,
    output logic [mmf_pkg::MSG_W-1:0]      rx_sc2_irq_data
);
    localparam int unsigned W = mmf_pkg::MSG_W;

    typedef struct packed {
        logic                                 tick_en;
        logic [mmf_pkg::TICK_CNT_W-1:0]       tick_cnt;
        logic                                 tick;
        logic [W-1:0]                         low;
        logic [W-1:0]                         hq0;
        logic [W-1:0]                         hq1;
        logic [1:0]                           hq_n;
        logic [W-1:0]                         sc1_out;
        logic                                 sc1_high;
        logic [W-1:0]                         sc2;
        logic [W-1:0]                         sc2_out;
        logic                                 mfe;
    } mmf_core_s;
    mmf_core_s s_q, s_d;

    function automatic logic is_one_shot(input logic [W-1:0] m);
        is_one_shot = (m == mmf_pkg::MSG_LP) || (m == mmf_pkg::MSG_DTSE) || (m == mmf_pkg::MSG_FECV);
    endfunction : is_one_shot

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        s_d.mfe  = s_loop_code_violation; // [RULE5]
        if (tick_interrupt_enable_cmd) begin
            s_d.tick_en = 1'b1;
        end
        if (s_q.tick_en) begin
            if (s_q.tick_cnt == mmf_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
                s_d.tick_cnt = '0;
                s_d.tick     = 1'b1; // [RULE1]
            end else begin
                s_d.tick_cnt = s_q.tick_cnt + 1'b1;
            end
        end
        if (sc1_low_priority_tx_we) begin
            s_d.low = sc1_low_priority_tx_wdata; // [RULE16]
        end
        if (sc2_tx_we) begin
            s_d.sc2 = sc2_tx_wdata;
        end
        // boundary pops first, so a same-cycle write lands behind what remains
        if (mf_boundary) begin
            s_d.sc2_out = s_q.sc2;
            if (s_q.hq_n != 2'd0) begin
                s_d.sc1_out  = s_q.hq0; // [RULE3]
                s_d.sc1_high = 1'b1;
                s_d.hq0      = s_q.hq1; // [RULE2]
                s_d.hq_n     = s_q.hq_n - 2'd1;
            end else begin
                s_d.sc1_out  = s_q.low; // [RULE3] [RULE16]
                s_d.sc1_high = 1'b0;
            end
        end
        if (sc1_high_priority_tx_queue_we) begin
            unique case (s_d.hq_n)
                2'd0: begin
                    s_d.hq0  = sc1_high_priority_tx_queue_wdata;
                    s_d.hq_n = 2'd1;
                end
                2'd1: begin
                    s_d.hq1  = sc1_high_priority_tx_queue_wdata; // [RULE2]
                    s_d.hq_n = 2'd2;
                end
                default: begin
                    s_d.hq0 = s_d.hq1; // [RULE4]
                    s_d.hq1 = sc1_high_priority_tx_queue_wdata;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.low     <= mmf_pkg::MSG_IDLE;
            s_q.sc1_out <= mmf_pkg::MSG_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign sc1_line_tx               = s_q.sc1_out;
    assign sc1_line_high             = s_q.sc1_high;
    assign sc2_line_tx               = s_q.sc2_out;
    assign multiframe_tick_interrupt = s_q.tick;
    assign rx_multiframe_error       = s_q.mfe;

    mmf_rx_validate #(.W(W), .COUNT(mmf_pkg::VALIDATE_COUNT), .ONCE_OK(1'b1)) u_rx_sc1 (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .msg_valid    (rx_sc1_valid),
        .msg_data     (rx_sc1_data),
        .msg_one_shot (is_one_shot(rx_sc1_data)), // [RULE6]
        .irq          (rx_sc1_irq),
        .irq_data     (rx_sc1_irq_data)
    );

    mmf_rx_validate #(.W(W), .COUNT(mmf_pkg::VALIDATE_COUNT), .ONCE_OK(1'b0)) u_rx_sc2 (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .msg_valid    (rx_sc2_valid),
        .msg_data     (rx_sc2_data),
        .msg_one_shot (1'b0),
        .irq          (rx_sc2_irq), // [RULE8]
        .irq_data     (rx_sc2_irq_data)
    );

    // tick pacing seen by firmware
    AST_TICK_ONLY_ENABLED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        s_q.tick |-> s_q.tick_en)
        else $error("tick while disabled");
    AST_TICK_EN_STICKY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        s_q.tick_en |=> s_q.tick_en)
        else $error("tick enable lost");
    AST_TICK_NEEDS_CMD: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        !s_q.tick_en && !tick_interrupt_enable_cmd |=> !s_q.tick_en)
        else $error("tick enabled without command");
    AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        s_q.tick |=> !s_q.tick[*8])
        else $error("ticks too close");

    // transmit queue order and line holding
    AST_HIGH_FIRST: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
        mf_boundary && s_q.hq_n != 2'd0 |=> sc1_line_high && sc1_line_tx == $past(s_q.hq0))
        else $error("queued entry not sent");
    AST_LOW_WHEN_EMPTY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3] [RULE16]
        mf_boundary && s_q.hq_n == 2'd0 |=> !sc1_line_high && sc1_line_tx == $past(s_q.low))
        else $error("low value not sent");
    AST_LINE_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2] [RULE16]
        !mf_boundary |=> $stable(sc1_line_tx) && $stable(sc1_line_high) && $stable(sc2_line_tx))
        else $error("line value changed between boundaries");
    AST_LOW_LOADS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
        sc1_low_priority_tx_we |=> s_q.low == $past(sc1_low_priority_tx_wdata))
        else $error("low register write lost");
    AST_LOW_KEEPS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
        !sc1_low_priority_tx_we |=> $stable(s_q.low))
        else $error("low register changed without a write");
    AST_QUEUE_BOUND: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        s_q.hq_n <= 2'd2)
        else $error("queue overrun");
    AST_PUSH_EMPTY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        sc1_high_priority_tx_queue_we && !mf_boundary && s_q.hq_n == 2'd0
        |=> s_q.hq_n == 2'd1 && s_q.hq0 == $past(sc1_high_priority_tx_queue_wdata))
        else $error("first entry not queued");
    AST_PUSH_SECOND: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        sc1_high_priority_tx_queue_we && !mf_boundary && s_q.hq_n == 2'd1
        |=> s_q.hq_n == 2'd2 && $stable(s_q.hq0) && s_q.hq1 == $past(sc1_high_priority_tx_queue_wdata))
        else $error("second entry not queued");
    AST_POP_ORDER: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        mf_boundary && !sc1_high_priority_tx_queue_we && s_q.hq_n == 2'd2
        |=> s_q.hq_n == 2'd1 && s_q.hq0 == $past(s_q.hq1))
        else $error("queue order lost on pop");
    AST_POP_THEN_PUSH: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2] [RULE3]
        mf_boundary && sc1_high_priority_tx_queue_we && s_q.hq_n == 2'd2
        |=> s_q.hq_n == 2'd2 && s_q.hq0 == $past(s_q.hq1) && s_q.hq1 == $past(sc1_high_priority_tx_queue_wdata))
        else $error("same-cycle pop and push wrong");
    AST_OVERWRITE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
        sc1_high_priority_tx_queue_we && !mf_boundary && s_q.hq_n == 2'd2
        |=> s_q.hq0 == $past(s_q.hq1) && s_q.hq1 == $past(sc1_high_priority_tx_queue_wdata))
        else $error("full-queue overwrite wrong");

    // receive side and S-loop error
    AST_MFE_FOLLOWS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
        s_loop_code_violation |=> rx_multiframe_error)
        else $error("violation lost");
    AST_MFE_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
        !s_loop_code_violation |=> !rx_multiframe_error)
        else $error("error shown without a violation");
    AST_ONE_SHOT_IRQ: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
        rx_sc1_valid && is_one_shot(rx_sc1_data) |=> rx_sc1_irq && rx_sc1_irq_data == $past(rx_sc1_data))
        else $error("one-shot irq missing");

    // main scenarios
    COV_TICK: cover property (@(posedge mclk) s_q.tick);
    COV_QUEUE_FULL_WRITE: cover property (@(posedge mclk) sc1_high_priority_tx_queue_we && s_q.hq_n == 2'd2);
    COV_HIGH_SENT: cover property (@(posedge mclk) mf_boundary && s_q.hq_n != 2'd0);
    COV_SC1_IRQ: cover property (@(posedge mclk) rx_sc1_irq);
    COV_SC2_IRQ: cover property (@(posedge mclk) rx_sc2_irq);
endmodule : mmf_core

// ---- mmf_core_tb_top.sv ----
// self-checking bench for the maintenance multiframe messaging core
// assumes mmf_pkg and mmf_line_model are compiled first
`timescale 1ns/10ps
module mmf_core_tb_top;
    localparam int unsigned TICK = 20;
    logic        mclk, rst_n, mf_b, viol, rv1, rv2, high, tick, mferr, irq1, irq2;
    logic [3:0]  we, wd, rd1, rd2, line1, line2, irqd1, irqd2;
    int          errors, num_checks, n;
    int          ticks_seen = 0;
    mmf_core #(.TICK_CYCLES(TICK)) dut_u (.mclk(mclk), .rst_n(rst_n), .tick_interrupt_enable_cmd(we[3]),
        .sc1_low_priority_tx_we(we[0]), .sc1_low_priority_tx_wdata(wd), .sc1_high_priority_tx_queue_we(we[1]),
        .sc1_high_priority_tx_queue_wdata(wd), .sc2_tx_we(we[2]), .sc2_tx_wdata(wd), .mf_boundary(mf_b),
        .s_loop_code_violation(viol), .rx_sc1_valid(rv1), .rx_sc1_data(rd1), .rx_sc2_valid(rv2),
        .rx_sc2_data(rd2), .sc1_line_tx(line1), .sc1_line_high(high), .sc2_line_tx(line2),
        .multiframe_tick_interrupt(tick), .rx_multiframe_error(mferr), .rx_sc1_irq(irq1),
        .rx_sc1_irq_data(irqd1), .rx_sc2_irq(irq2), .rx_sc2_irq_data(irqd2));
    mmf_line_model u_line (.mclk(mclk), .mf_boundary(mf_b), .s_loop_code_violation(viol), .rx_sc1_valid(rv1),
        .rx_sc1_data(rd1), .rx_sc2_valid(rv2), .rx_sc2_data(rd2));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) if (tick === 1'b1) ticks_seen <= ticks_seen + 1;
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input int unsigned idx, input logic [3:0] d);
        @(posedge mclk);
        we[idx] <= 1'b1;
        wd <= d;
        @(posedge mclk);
        we <= 4'h0;
    endtask : wr
    task automatic mf(input logic [3:0] exp, input logic exp_high);
        u_line.frame(1'b0);
        #1;
        chk("sc1_line_tx", exp, line1);
        chk("sc1_line_high", exp_high, high);
    endtask : mf
    task automatic rxc(input bit sc2, input logic [3:0] d, input logic exp_irq);
        u_line.rx(sc2, d);
        #1;
        chk(sc2 ? "rx_sc2_irq" : "rx_sc1_irq", exp_irq, sc2 ? irq2 : irq1);
        if (exp_irq) chk("rx_irq_data", d, sc2 ? irqd2 : irqd1);
    endtask : rxc
    initial begin
        {rst_n, we, wd, errors, num_checks} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("reset sc1_line_tx", mmf_pkg::MSG_IDLE, line1);
        chk("reset sc1_line_high", 1'b0, high);
        wr(0, 4'h5);
        mf(4'h5, 1'b0);
        mf(4'h5, 1'b0);
        wr(1, 4'hA);
        wr(1, 4'hB);
        mf(4'hA, 1'b1);
        mf(4'hB, 1'b1);
        mf(4'h5, 1'b0);
        wr(1, mmf_pkg::MSG_DTSE);
        wr(1, mmf_pkg::MSG_FECV);
        wr(1, mmf_pkg::MSG_LP);
        wr(0, mmf_pkg::MSG_LP);
        mf(mmf_pkg::MSG_FECV, 1'b1);
        mf(mmf_pkg::MSG_LP, 1'b1);
        mf(mmf_pkg::MSG_LP, 1'b0);
        $display("test transmit queue done");
        u_line.frame(1'b1);
        #1;
        chk("rx_multiframe_error", 1'b1, mferr);
        @(posedge mclk);
        #1;
        chk("rx_multiframe_error clear", 1'b0, mferr);
        repeat (2) rxc(1'b0, mmf_pkg::MSG_LP, 1'b1);
        repeat (2) rxc(1'b0, mmf_pkg::MSG_DTSE, 1'b1);
        repeat (2) rxc(1'b0, mmf_pkg::MSG_FECV, 1'b1);
        for (n = 0; n < 4; n++) rxc(1'b0, 4'h7, n == 2);
        for (n = 0; n < 4; n++) rxc(1'b1, 4'h9, n == 2);
        for (n = 0; n < 4; n++) rxc(1'b1, mmf_pkg::MSG_LP, n == 2);
        $display("test receive validation done");
        wr(2, 4'h6);
        mf(mmf_pkg::MSG_LP, 1'b0);
        chk("sc2_line_tx", 4'h6, line2);
        chk("tick before enable", 0, ticks_seen);
        wr(3, 4'h1);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge mclk);
                #1;
                n++;
            end while (tick !== 1'b1 && n < 100);
            chk("tick interval", TICK, n);
        end
        wr(0, mmf_pkg::MSG_IDLE);
        mf(mmf_pkg::MSG_IDLE, 1'b0);
        chk("tick count", 2, ticks_seen);
        $display("test tick done");
        close_out();
    end
    initial begin
        #(40 * 20000);
        errors++;
        close_out();
    end
endmodule : mmf_core_tb_top

// ---- mmf_line_model.sv ----
// remote line model: multiframe boundaries, received messages and S-loop faults
// assumes the bench calls its tasks from one process, one transfer at a time
`timescale 1ns/10ps
module mmf_line_model (
    input  wire logic       mclk,
    output logic            mf_boundary,
    output logic            s_loop_code_violation,
    output logic            rx_sc1_valid,
    output logic [3:0]      rx_sc1_data,
    output logic            rx_sc2_valid,
    output logic [3:0]      rx_sc2_data
);
    initial begin
        {mf_boundary, s_loop_code_violation, rx_sc1_valid, rx_sc2_valid} = 4'h0;
        rx_sc1_data = 4'h5;
        rx_sc2_data = 4'hA;
    end
    task automatic frame(input bit fault);
        @(posedge mclk);
        if (fault) s_loop_code_violation <= 1'b1;
        else mf_boundary <= 1'b1;
        @(posedge mclk);
        {mf_boundary, s_loop_code_violation} <= 2'h0;
    endtask : frame
    task automatic rx(input bit sc2, input logic [3:0] d);
        @(posedge mclk);
        rx_sc1_valid <= !sc2;
        rx_sc2_valid <= sc2;
        rx_sc1_data <= d;
        rx_sc2_data <= d;
        @(posedge mclk);
        {rx_sc1_valid, rx_sc2_valid} <= 2'h0;
        // data is no longer valid once the strobe drops, so show junk
        rx_sc1_data <= ~d;
        rx_sc2_data <= ~d;
    endtask : rx
endmodule : mmf_line_model

// ---- mmf_pkg.sv ----
// package for the maintenance multiframe messaging block
// assumes a 25 MHz mclk and 5 ms multiframes of 20 frames each
package mmf_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_MS         = 30;
    localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned TICK_CNT_W      = 20;
    localparam int unsigned MSG_W           = 4;
    localparam int unsigned VALIDATE_COUNT  = 3;
    localparam int unsigned VCNT_W          = 2;
    localparam logic [3:0]  MSG_IDLE        = 4'hF;
    localparam logic [3:0]  MSG_LP          = 4'h0;
    localparam logic [3:0]  MSG_DTSE        = 4'h1;
    localparam logic [3:0]  MSG_FECV        = 4'h2;
endpackage : mmf_pkg

// ---- mmf_rx_validate.sv ----
// receive validator for one terminal-side maintenance channel
// assumes msg_valid pulses once per received multiframe message
`timescale 1ns/10ps
module mmf_rx_validate #(
    parameter int unsigned W     = 4,
    parameter int unsigned COUNT = 3,
    parameter bit          ONCE_OK = 1'b0
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         msg_valid,
    input  wire logic [W-1:0] msg_data,
    input  wire logic         msg_one_shot,
    output logic              irq,
    output logic [W-1:0]      irq_data
);
    typedef struct packed {
        logic [W-1:0] last;
        logic [1:0]   cnt;
        logic         irq;
        logic [W-1:0] data;
    } mmf_rxv_s;
    mmf_rxv_s s_q, s_d;

    always_comb begin
        s_d     = s_q;
        s_d.irq = 1'b0;
        if (msg_valid) begin
            if (ONCE_OK && msg_one_shot) begin
                // every occurrence reported, no repeat filter
                s_d.irq  = 1'b1; // [RULE6]
                s_d.data = msg_data;
                s_d.last = msg_data;
                s_d.cnt  = 2'(COUNT);
            end else if (msg_data != s_q.last) begin
                s_d.last = msg_data;
                s_d.cnt  = 2'd1;
            end else if (s_q.cnt < 2'(COUNT)) begin
                s_d.cnt = s_q.cnt + 2'd1;
                if (s_q.cnt + 2'd1 == 2'(COUNT)) begin
                    // third identical copy only; later copies stay silent
                    s_d.irq  = 1'b1; // [RULE7] [RULE8]
                    s_d.data = msg_data;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign irq      = s_q.irq;
    assign irq_data = s_q.data;

    AST_NO_IRQ_WITHOUT_MSG: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
        s_q.irq |-> $past(msg_valid))
        else $error("irq without a message");
    AST_REPEAT_SILENT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7] [RULE8]
        msg_valid && !(ONCE_OK && msg_one_shot) && msg_data == s_q.last && s_q.cnt == 2'(COUNT)
        |=> !s_q.irq)
        else $error("repeat raised an irq");
endmodule : mmf_rx_validate
